// File: src/irq_aggregator_pkg.sv
// package for the board interrupt status aggregator: register fields and layout
// assumes one 25 MHz clock and a synchronous active-high reset
package irq_aggregator_pkg;

  localparam int unsigned REG_WIDTH = 16;
  localparam int unsigned EDGE_COUNT = 4;
  localparam int unsigned LEVEL_COUNT = 7;
  localparam int unsigned EDGE_BASE = 0;
  localparam int unsigned LEVEL_BASE = 8;
  localparam int unsigned SYNC_STAGES = 2;

  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  // positions that hold a source; bits 4..7 and 15 are reserved
  localparam logic [15:0] SOURCE_BITS = 16'h7F0F;
  localparam logic [15:0] EDGE_BITS = 16'h000F;

  // register select codes on the local register port
  localparam logic [1:0] SEL_STATUS = 2'h0;
  localparam logic [1:0] SEL_MASK_SET = 2'h1;
  localparam logic [1:0] SEL_MASK_CLEAR = 2'h2;
  localparam logic [1:0] SEL_MASK = 2'h3;

  // edge-type event inputs, bit order as in the status register
  typedef struct packed {
    logic host_overcurrent_event;
    logic otg_overcurrent_event;
    logic pushbutton_event;
    logic battery_low_event;
  } edge_src_t;

  // level-type inputs, bit order as in the status register
  typedef struct packed {
    logic comm_engine_irq_two;
    logic comm_engine_irq_one;
    logic synthesizer_irq;
    logic ext_serial_b_irq;
    logic ext_serial_a_irq;
    logic usb_fullspeed_irq;
    logic network_ctrl_irq;
  } level_src_t;

  // register access request from the bus-decoding logic
  typedef struct packed {
    logic wr;
    logic [1:0] sel;
    logic [15:0] wdata;
  } reg_req_t;

endpackage

// File: src/irq_input_sync.sv
// two-stage synchroniser for a group of asynchronous inputs
// assumes inputs are unrelated to clk; the first stage feeds only the second
`timescale 1ns/1ps
module irq_input_sync #(
  parameter int unsigned WIDTH = 11
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule

// File: src/irq_status_aggregator.sv
// board interrupt status aggregator: status, write-one-to-clear edge bits, set/clear mask, combined output
// assumes the bus decoder hands over one-cycle register requests on the clk domain
`timescale 1ns/1ps

// Contract
// - every board interrupt source passes through this block and is merged onto one output.
// - each source has its own mask bit able to block it from the output.
// - an edge-type pending bit is set on any transition of its input, rising or falling.
// - a write with a one at an edge-type bit clears that pending bit.
// - a write with a zero at an edge-type bit leaves it unchanged.
// - a level-type bit reads pending while its input is active, with no latching.
// - writes do not alter level-type bits; they keep following their inputs.
// - the status register can be read at any time.
// - bits 0..3 are battery low, push button, otg overcurrent and host overcurrent, write-one-to-clear.
// - bits 8..14 are network, usb full speed, serial a, serial b, synthesizer, comm engine one and two.
// - bits 4..7 and 15 are reserved and read zero, and the register resets to zero.
// - a masked source still shows pending but does not drive the output; unmasking a pending source asserts it at once.
// - mask one enables, zero masks; set and clear addresses act on the bits written with one.
// - all eleven masked sources are ORed into one output that is high while any enabled source is pending.
module irq_status_aggregator (
  input wire logic clk,
  input wire logic sys_rst,
  input wire irq_aggregator_pkg::edge_src_t edge_src,
  input wire irq_aggregator_pkg::level_src_t level_src,
  input wire irq_aggregator_pkg::reg_req_t reg_req,
  input wire logic reg_valid,
  output logic reg_ready,
  output logic [15:0] reg_rdata,
  output logic combined_irq_out
);

  localparam int unsigned SRC_TOTAL = irq_aggregator_pkg::EDGE_COUNT + irq_aggregator_pkg::LEVEL_COUNT;

  logic [SRC_TOTAL-1:0] raw_src;
  logic [SRC_TOTAL-1:0] sync_src;
  logic [irq_aggregator_pkg::EDGE_COUNT-1:0] edge_now;
  logic [irq_aggregator_pkg::EDGE_COUNT-1:0] edge_prev;
  logic [1:0] prime_count;
  wire edge_primed = prime_count > 2'(irq_aggregator_pkg::SYNC_STAGES);
  logic [irq_aggregator_pkg::EDGE_COUNT-1:0] edge_pending;
  logic [irq_aggregator_pkg::EDGE_COUNT-1:0] next_edge_pending;
  logic [irq_aggregator_pkg::LEVEL_COUNT-1:0] level_now;
  logic [15:0] status_word;
  logic [15:0] mask;
  logic [15:0] next_mask;
  logic [15:0] enabled_pending;
  logic [15:0] read_mux;
  wire write_status = reg_valid && reg_req.wr && (reg_req.sel == irq_aggregator_pkg::SEL_STATUS);
  wire write_set = reg_valid && reg_req.wr && (reg_req.sel == irq_aggregator_pkg::SEL_MASK_SET);
  wire write_clear = reg_valid && reg_req.wr && (reg_req.sel == irq_aggregator_pkg::SEL_MASK_CLEAR);
  wire write_mask = reg_valid && reg_req.wr && (reg_req.sel == irq_aggregator_pkg::SEL_MASK);

  assign raw_src = {level_src, edge_src};

  irq_input_sync #(
    .WIDTH(SRC_TOTAL)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(raw_src),
    .sync_out(sync_src)
  );

  assign edge_now = sync_src[irq_aggregator_pkg::EDGE_COUNT-1:0];
  assign level_now = sync_src[SRC_TOTAL-1:irq_aggregator_pkg::EDGE_COUNT];

  // per-bit pending update: set on change wins over a same-cycle clear
  genvar gi;
  generate
    for (gi = 0; gi < irq_aggregator_pkg::EDGE_COUNT; gi++) begin : g_edge
      wire changed = edge_primed && (edge_now[gi] != edge_prev[gi]);
      wire clear_hit = write_status && reg_req.wdata[irq_aggregator_pkg::EDGE_BASE + gi];
      assign next_edge_pending[gi] = changed | (edge_pending[gi] & ~clear_hit);
    end
  endgenerate

  // no false edge after reset
  // compares wait until both the synchroniser and edge_prev hold live input,
  // so an input that idles high through reset cannot fake an edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      edge_prev <= '0;
      prime_count <= '0;
      edge_pending <= '0;
    end else begin
      edge_prev <= edge_now;
      if (!edge_primed) begin
        prime_count <= 2'(prime_count + 2'h1);
      end
      edge_pending <= next_edge_pending;
    end
  end

  // status layout; level bits are live, reserved bits zero
  assign status_word = {1'b0, level_now, 4'h0, edge_pending} & irq_aggregator_pkg::SOURCE_BITS;

  // set and clear act only on ones; direct write is a plain load
  assign next_mask = write_mask ? (reg_req.wdata & irq_aggregator_pkg::SOURCE_BITS) :
                     write_set ? (mask | (reg_req.wdata & irq_aggregator_pkg::SOURCE_BITS)) :
                     write_clear ? (mask & ~reg_req.wdata) : mask;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask <= irq_aggregator_pkg::MASK_RESET;
    end else begin
      mask <= next_mask;
    end
  end

  // mask gates output only, status keeps showing
  assign enabled_pending = status_word & mask;
  // combined OR, combinational so unmasking acts at once
  assign combined_irq_out = |enabled_pending;

  assign reg_ready = 1'b1;
  assign read_mux = (reg_req.sel == irq_aggregator_pkg::SEL_STATUS) ? status_word :
                    (reg_req.sel == irq_aggregator_pkg::SEL_MASK) ? mask : 16'h0000;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= irq_aggregator_pkg::STATUS_RESET;
    end else if (reg_valid && !reg_req.wr) begin
      reg_rdata <= read_mux;
    end
  end

endmodule

// File: bench/irq_aggregator_checker_assertions.sv
// checker for the interrupt aggregator ports
// assumes one clock with synchronous active-high reset
`timescale 1ns/1ps
module irq_aggregator_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire irq_aggregator_pkg::edge_src_t edge_src,
  input wire irq_aggregator_pkg::level_src_t level_src,
  input wire irq_aggregator_pkg::reg_req_t reg_req,
  input wire logic reg_valid,
  input wire logic reg_ready,
  input wire logic [15:0] reg_rdata,
  input wire logic combined_irq_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // synchroniser is empty just after reset, so input relations wait three cycles
  logic [2:0] rst_hist;
  always_ff @(posedge clk) rst_hist <= {rst_hist[1:0], sys_rst};
  wire settled = rst_hist == 3'h0;
  wire rd_st = reg_valid && !reg_req.wr && reg_req.sel == 2'h0;
  wire wr_st = reg_valid && reg_req.wr && reg_req.sel == 2'h0;
  a_ready_high: assert property (reg_ready) else $error("ready low");
  a_reset_clear: assert property (disable iff (1'b0) sys_rst |=> reg_rdata == 16'h0000 && !combined_irq_out)
    else $error("reset values wrong");
  a_reserved_zero: assert property (rd_st |=> (reg_rdata & 16'h80F0) == 16'h0000) else $error("reserved set");
  a_rdata_hold: assert property (!(reg_valid && !reg_req.wr) |=> $stable(reg_rdata)) else $error("rdata moved");
  a_level_follow: assert property (rd_st && settled && level_src == $past(level_src) &&
    level_src == $past(level_src, 2) |=> reg_rdata[14:8] == $past(level_src)) else $error("level bits wrong");
  a_mask_quiet: assert property (reg_valid && reg_req.wr && reg_req.sel == 2'h2 && reg_req.wdata == 16'h7F0F
    |=> !combined_irq_out) else $error("irq with all masked");
  a_unmask_fires: assert property (reg_valid && reg_req.wr && reg_req.sel == 2'h1 && settled &&
    |(reg_req.wdata[14:8] & level_src & $past(level_src) & $past(level_src, 2)) |=> combined_irq_out)
    else $error("unmask did not fire");
  a_w1c_clears: assert property (wr_st && settled && reg_req.wdata[3:0] == 4'hF && $stable(edge_src) &&
    $past(edge_src) == $past(edge_src, 2) && $past(edge_src, 2) == $past(edge_src, 3)
    ##1 $stable(edge_src) ##1 rd_st && $stable(edge_src) |=> reg_rdata[3:0] == 4'h0) else $error("w1c failed");
endmodule
bind irq_status_aggregator irq_aggregator_checker chk_i (.clk(clk), .sys_rst(sys_rst), .edge_src(edge_src),
  .level_src(level_src), .reg_req(reg_req), .reg_valid(reg_valid), .reg_ready(reg_ready), .reg_rdata(reg_rdata),
  .combined_irq_out(combined_irq_out));

// File: bench/host_bus_model.sv
// host model: one-cycle register requests, read data collected after the taking edge
// assumes reg_ready is held high, so every strobe is taken at the next rising edge
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clk,
  input wire logic [15:0] reg_rdata,
  output irq_aggregator_pkg::reg_req_t reg_req,
  output logic reg_valid
);
  initial begin
    reg_req = '0;
    reg_valid = 1'b0;
  end
  task automatic access(input logic wr, input logic [1:0] sel, input logic [15:0] wd, output logic [15:0] rd);
    @(negedge clk);
    reg_req = {wr, sel, wd};
    reg_valid = 1'b1;
    @(negedge clk);
    rd = reg_rdata;
    reg_valid = 1'b0;
    // released fields flip so a stale request is never mistaken for a live one
    reg_req = ~reg_req;
  endtask
endmodule

// File: bench/tb.sv
// self-checking bench for the interrupt status aggregator
// assumes the host model issues every register request
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  irq_aggregator_pkg::edge_src_t edge_src = '0;
  irq_aggregator_pkg::level_src_t level_src = '0;
  irq_aggregator_pkg::reg_req_t reg_req;
  logic reg_valid, reg_ready, combined_irq_out;
  logic [15:0] reg_rdata, rd;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  initial forever #20 clk = ~clk;
  irq_status_aggregator uut (.clk(clk), .sys_rst(sys_rst), .edge_src(edge_src), .level_src(level_src),
    .reg_req(reg_req), .reg_valid(reg_valid), .reg_ready(reg_ready), .reg_rdata(reg_rdata),
    .combined_irq_out(combined_irq_out));
  host_bus_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_req(reg_req), .reg_valid(reg_valid));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [1:0] sel, input logic [15:0] exp);
    host.access(1'b0, sel, 16'h0000, rd);
    chk(rd, exp);
  endtask
  task automatic wr(input logic [1:0] sel, input logic [15:0] wd);
    host.access(1'b1, sel, wd, rd);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    rd_chk(2'h0, 16'h0000);
    rd_chk(2'h3, 16'h0000);
    edge_src = 4'hF;
    repeat (6) @(negedge clk);
    rd_chk(2'h0, 16'h000F);
    chk({15'h0, combined_irq_out}, 16'h0000);
    wr(2'h0, 16'h0005);
    rd_chk(2'h0, 16'h000A);
    wr(2'h0, 16'hFFFF);
    rd_chk(2'h0, 16'h0000);
    edge_src = 4'hE;
    repeat (6) @(negedge clk);
    rd_chk(2'h0, 16'h0001);
    wr(2'h0, 16'h0001);
    $display("edge tests done");
    level_src = 7'h55;
    repeat (6) @(negedge clk);
    rd_chk(2'h0, 16'h5500);
    wr(2'h0, 16'hFFFF);
    rd_chk(2'h0, 16'h5500);
    wr(2'h1, 16'hFFFF);
    rd_chk(2'h3, 16'h7F0F);
    chk({15'h0, combined_irq_out}, 16'h0001);
    wr(2'h2, 16'h7F0F);
    chk({15'h0, combined_irq_out}, 16'h0000);
    wr(2'h1, 16'h0100);
    chk({15'h0, combined_irq_out}, 16'h0001);
    // host services the peripheral, which drops its request
    level_src = 7'h00;
    repeat (6) @(negedge clk);
    rd_chk(2'h0, 16'h0000);
    chk({15'h0, combined_irq_out}, 16'h0000);
    $display("level and mask tests done");
    wr(2'h3, 16'hFFFF);
    rd_chk(2'h3, 16'h7F0F);
    wr(2'h2, 16'h0100);
    rd_chk(2'h3, 16'h7E0F);
    rd_chk(2'h1, 16'h0000);
    rd_chk(2'h2, 16'h0000);
    // edge inputs idling high across a second reset must not latch a phantom edge
    edge_src = 4'hF;
    sys_rst = 1'b1;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    repeat (6) @(negedge clk);
    rd_chk(2'h0, 16'h0000);
    rd_chk(2'h3, 16'h0000);
    chk({15'h0, combined_irq_out}, 16'h0000);
    edge_src = 4'h0;
    repeat (6) @(negedge clk);
    rd_chk(2'h0, 16'h000F);
    $display("reset and direct mask tests done");
    report_and_stop();
  end
endmodule
